// ===== hbdl_host_bus_decode_latch.sv
// Host bus front end: address latches, strobe decode, byte lanes, page register and selects.
`timescale 1ns/1ps
`include "hbdl_cfg.svh"
module hbdl_host_bus_decode_latch
  import hbdl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic highAddrLatchSel,
  input wire logic highAddrRoleSel,
  input wire logic wideBusSel,
  input wire logic muxedBusSel,
  input wire logic nonmuxLatchSel,
  input wire logic spaceSplitSel,
  input wire logic strobeStyleSel,
  input wire logic dataStrobeSel,
  input wire logic aleActiveHighSel,
  input wire logic addrStrobe,
  input wire logic rdStrobePin,
  input wire logic wrStrobePin,
  input wire logic sharedPin,
  input wire logic [15:0] addrIn,
  input wire logic [3:0] highAddrIn,
  input wire logic [15:0] dataIn,
  input wire logic ioBaseSelect,
  input wire logic [7:0] bankDecode,
  input wire logic sramDecode,
  output logic [15:0] latchedAddr,
  output logic [3:0] highAddrLogic,
  output logic [3:0] decoderHighAddr,
  output logic [3:0] pageOutputs,
  output logic [7:0] codeBankSelects,
  output logic sramSelect,
  output logic sramRead,
  output logic sramWrite,
  output logic sramWordMode,
  output logic codeRead,
  output logic programFetch,
  output logic readStrobe,
  output logic writeStrobe,
  output logic lowerLaneEn,
  output logic upperLaneEn,
  output logic [15:0] dataOut,
  output logic [15:0] dataOe
);
  hbdl_state_t state_q;
  hbdl_state_t state_d;
  hbdl_cfg_t cfg;
  hbdl_cfg_t cfgIn;
  logic strobeActive;
  logic lowLatchEn;
  logic highLatchEn;
  logic pinLatchEn;
  logic [7:0] lowSrc;
  logic [7:0] highSrc;
  logic sharedLatched;
  logic [3:0] extHighAddr;
  logic splitActive;
  logic pageHit;
  logic pageWrite;
  logic pageRead;

  hbdl_strobe_if strobeBus ();

  assign cfgIn = '{highAddrLatchSel, highAddrRoleSel, wideBusSel, muxedBusSel, nonmuxLatchSel,
                   spaceSplitSel, strobeStyleSel, dataStrobeSel, aleActiveHighSel};
  assign cfg = state_q.cfg;

  // The strobe polarity is folded in once so every latch sees the same active level.
  // polarity select
  assign strobeActive = (addrStrobe == cfg.aleActiveHighSel);

  assign lowLatchEn = cfg.muxedBusSel || cfg.nonmuxLatchSel;
  assign highLatchEn = cfg.muxedBusSel ? cfg.wideBusSel : cfg.nonmuxLatchSel;
  assign pinLatchEn = cfg.wideBusSel && cfg.muxedBusSel;

  // In multiplexed modes the low address byte rides on the data pins of the same lane, and the high byte does too on a wide bus.
  assign lowSrc = cfg.muxedBusSel ? dataIn[7:0] : addrIn[7:0];
  assign highSrc = (cfg.muxedBusSel && cfg.wideBusSel) ? dataIn[15:8] : addrIn[15:8];

  hbdl_addr_latch #(.W(8)) uLowLatch (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .latchEn(lowLatchEn),
    .strobeActive(strobeActive),
    .din(lowSrc),
    .dout(latchedAddr[7:0])
  );

  hbdl_addr_latch #(.W(8)) uHighLatch (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .latchEn(highLatchEn),
    .strobeActive(strobeActive),
    .din(highSrc),
    .dout(latchedAddr[15:8])
  );

  hbdl_addr_latch #(.W(1)) uPinLatch (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .latchEn(pinLatchEn),
    .strobeActive(strobeActive),
    .din(sharedPin),
    .dout(sharedLatched)
  );

  hbdl_addr_latch #(.W(4)) uExtLatch (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .latchEn(cfg.highAddrLatchSel),
    .strobeActive(strobeActive),
    .din(highAddrIn),
    .dout(extHighAddr)
  );

  assign decoderHighAddr = cfg.highAddrRoleSel ? extHighAddr : 4'h0;
  assign highAddrLogic = extHighAddr;

  assign strobeBus.style = cfg.strobeStyleSel ? (cfg.dataStrobeSel ? HBDL_DS : HBDL_ENA) : HBDL_SEP;
  assign strobeBus.rdPin = rdStrobePin;
  assign strobeBus.wrPin = wrStrobePin;

  hbdl_strobe_dec uDec (
    .bus(strobeBus.dec)
  );

  assign readStrobe = strobeBus.readAct;
  assign writeStrobe = strobeBus.writeAct;

  assign programFetch = !cfg.wideBusSel && !sharedLatched;

  assign lowerLaneEn = !cfg.wideBusSel || !latchedAddr[0];
  assign upperLaneEn = cfg.wideBusSel && !sharedLatched;

  // Without a fetch pin on a wide bus the spaces can only be combined.
  assign splitActive = cfg.spaceSplitSel && !cfg.wideBusSel;
  assign codeRead = splitActive ? programFetch : strobeBus.readAct;

  generate
    for (genvar n = 0; n < `HBDL_BANKS; n++) begin : gBank
      assign codeBankSelects[n] = bankDecode[n] && codeRead;
    end
  endgenerate

  assign sramSelect = sramDecode;
  assign sramRead = sramDecode && strobeBus.readAct;
  assign sramWrite = sramDecode && strobeBus.writeAct;
  assign sramWordMode = cfg.wideBusSel;

  assign pageHit = ioBaseSelect && (latchedAddr[7:0] == `HBDL_PAGE_OFS) && lowerLaneEn;
  assign pageWrite = pageHit && strobeBus.writeAct;
  assign pageRead = pageHit && strobeBus.readAct;

  always_comb begin
    state_d = state_q;
    if (!state_q.loaded) begin
      state_d.cfg = cfgIn;
      state_d.loaded = 1'b1;
    end
    if (pageWrite) begin
      state_d.page = dataIn[`HBDL_PAGE_MSB:`HBDL_PAGE_LSB];
    end
    // The page read answers one cycle later so the data pins come from flip-flops.
    state_d.rdOe = pageRead ? `HBDL_LOW_LANES : 16'h0000;
    state_d.rdData = 16'h0000;
    if (pageRead) begin
      state_d.rdData[`HBDL_PAGE_MSB:`HBDL_PAGE_LSB] = state_q.page;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q.cfg <= `HBDL_CFG_RST;
      state_q.loaded <= 1'b0;
      state_q.page <= `HBDL_PAGE_RST;
      state_q.rdData <= 16'h0000;
      state_q.rdOe <= 16'h0000;
    end else begin
      state_q <= state_d;
    end
  end

  assign pageOutputs = state_q.page;
  assign dataOut = state_q.rdData;
  assign dataOe = state_q.rdOe;

  AST_SEP_WRITE:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    (cfg == $past(cfg) && !cfg.strobeStyleSel && !wrStrobePin) |-> writeStrobe)
  else $error("Low write pin did not write in separate style.");

  AST_SEP_READ:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!cfg.strobeStyleSel && !rdStrobePin) |-> readStrobe)
  else $error("Low read pin did not read in separate style.");

  AST_ENA_STYLE:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    (cfg.strobeStyleSel && !cfg.dataStrobeSel) |->
      (readStrobe == (rdStrobePin && wrStrobePin)) && (writeStrobe == (rdStrobePin && !wrStrobePin)))
  else $error("Enable style decode is wrong.");

  AST_DS_STYLE:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    (cfg.strobeStyleSel && cfg.dataStrobeSel && rdStrobePin) |-> !readStrobe && !writeStrobe)
  else $error("Data strobe style acted with the strobe high.");

  AST_PAGE_WRITE:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    pageWrite |=> pageOutputs == $past(dataIn[3:0]))
  else $error("Page register did not take the written value.");

  AST_PAGE_READ:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    (pageRead && !pageWrite) |=> dataOe == 16'h00ff && dataOut[3:0] == pageOutputs && dataOut[15:4] == 12'h000)
  else $error("Page register read data is wrong.");

  AST_LANES:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    (cfg.wideBusSel && sharedLatched && latchedAddr[0]) |-> !lowerLaneEn && !upperLaneEn)
  else $error("A transfer was enabled for the no-transfer code.");

  AST_ROLE:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    !cfg.highAddrRoleSel |-> decoderHighAddr == 4'h0)
  else $error("Logic inputs reached the bank decode.");

  AST_BANKS:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    (codeBankSelects & ~bankDecode) == 8'h00)
  else $error("A bank was selected without its own decoder output.");

  AST_CFG_FROZEN:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_q.loaded |=> $stable(cfg))
  else $error("Configuration changed while running.");

  AST_SPLIT_FETCH:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    (splitActive && sharedLatched) |-> !codeRead)
  else $error("Code read without a low fetch strobe in separate spaces.");

  AST_EXT_PASS:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    !cfg.highAddrLatchSel |-> highAddrLogic == highAddrIn)
  else $error("High-order inputs did not pass through in transparent mode.");

  AST_ROLE_PASS:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    cfg.highAddrRoleSel |-> decoderHighAddr == highAddrLogic)
  else $error("Address lines did not reach the bank decode.");

  AST_LOW_PASS:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!cfg.muxedBusSel && !cfg.nonmuxLatchSel) |-> latchedAddr[7:0] == addrIn[7:0])
  else $error("Low address byte did not pass through.");

  AST_HIGH_PASS:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    (cfg.muxedBusSel ? !cfg.wideBusSel : !cfg.nonmuxLatchSel) |-> latchedAddr[15:8] == addrIn[15:8])
  else $error("High address byte did not pass through.");

  AST_PIN_PASS:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    !(cfg.wideBusSel && cfg.muxedBusSel) |-> sharedLatched == sharedPin)
  else $error("Shared pin did not pass through.");

  AST_OPEN_HIGH:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    (cfg.aleActiveHighSel && addrStrobe) |-> latchedAddr == {highSrc, lowSrc})
  else $error("Address latch was not transparent while the high strobe was up.");

  AST_OPEN_LOW:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!cfg.aleActiveHighSel && !addrStrobe) |-> latchedAddr == {highSrc, lowSrc})
  else $error("Address latch was not transparent while the low strobe was down.");

  AST_WIDE_NO_FETCH:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    cfg.wideBusSel |-> !programFetch)
  else $error("Program fetch was seen on a wide bus.");

  AST_NARROW_LANES:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    !cfg.wideBusSel |-> lowerLaneEn && !upperLaneEn)
  else $error("Upper lane was enabled on a narrow bus.");

  AST_COMBINED_READ:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    !splitActive |-> codeRead == readStrobe)
  else $error("Code read did not follow the read style in combined spaces.");

  AST_SEP_FETCH_READ:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    (splitActive && !sharedLatched) |-> codeRead)
  else $error("Low fetch strobe did not read code in separate spaces.");

  AST_SEP_NO_WRITE:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!cfg.strobeStyleSel && wrStrobePin) |-> !writeStrobe)
  else $error("Write qualifier rose with the write pin high.");

  AST_LANE_WORD:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    (cfg.wideBusSel && !sharedLatched && !latchedAddr[0]) |-> lowerLaneEn && upperLaneEn)
  else $error("Whole word code did not enable both lanes.");

  AST_DS_ACCESS:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    (cfg.strobeStyleSel && cfg.dataStrobeSel && !rdStrobePin) |->
      (readStrobe == wrStrobePin) && (writeStrobe == !wrStrobePin))
  else $error("Data strobe access did not follow the direction line.");

  AST_PAGE_HOLD:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    !pageWrite |=> $stable(pageOutputs))
  else $error("Page register changed without a write.");

  AST_OE_IDLE:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    !pageRead |=> dataOe == 16'h0000)
  else $error("Data pins were driven without a page read.");
endmodule

// ===== hbdl_cfg.svh
// Constants of the host bus decode and latch block.
`ifndef HBDL_CFG_SVH
`define HBDL_CFG_SVH
`define HBDL_PAGE_OFS 8'h18
`define HBDL_PAGE_LSB 0
`define HBDL_PAGE_MSB 3
`define HBDL_PAGE_RST 4'h0
`define HBDL_CFG_RST 9'h000
`define HBDL_BANKS 8
`define HBDL_LOW_LANES 16'h00ff
`endif

// ===== hbdl_pkg.sv
// Types shared by the host bus decode and latch modules.
package hbdl_pkg;
  typedef enum logic [1:0] {
    HBDL_SEP = 2'b00,
    HBDL_ENA = 2'b01,
    HBDL_DS = 2'b11
  } hbdl_style_t;

  typedef struct packed {
    logic highAddrLatchSel;
    logic highAddrRoleSel;
    logic wideBusSel;
    logic muxedBusSel;
    logic nonmuxLatchSel;
    logic spaceSplitSel;
    logic strobeStyleSel;
    logic dataStrobeSel;
    logic aleActiveHighSel;
  } hbdl_cfg_t;

  typedef struct packed {
    hbdl_cfg_t cfg;
    logic loaded;
    logic [3:0] page;
    logic [15:0] rdData;
    logic [15:0] rdOe;
  } hbdl_state_t;
endpackage

// ===== hbdl_strobe_if.sv
// Read and write strobe pins and their decoded qualifiers.
`timescale 1ns/1ps
interface hbdl_strobe_if;
  import hbdl_pkg::*;
  logic rdPin;
  logic wrPin;
  hbdl_style_t style;
  logic readAct;
  logic writeAct;
  modport dec (input rdPin, input wrPin, input style, output readAct, output writeAct);
  modport user (output rdPin, output wrPin, output style, input readAct, input writeAct);
endinterface

// ===== hbdl_addr_latch.sv
// Address latch that is transparent while the strobe is active and holds after it.
`timescale 1ns/1ps
module hbdl_addr_latch #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic latchEn,
  input wire logic strobeActive,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] held;
  } hbdl_latch_t;

  hbdl_latch_t state_q;
  hbdl_latch_t state_d;

  always_comb begin
    state_d = state_q;
    if (strobeActive) begin
      state_d.held = din;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign dout = (!latchEn || strobeActive) ? din : state_q.held;

  AST_LATCH_CAPTURE:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    (latchEn && !strobeActive && $past(strobeActive)) |-> dout == $past(din))
  else $error("Latch did not capture on the trailing strobe edge.");

  AST_LATCH_STABLE:
  assert property (@(posedge sys_clk) disable iff (!reset_n)
    (latchEn && $past(latchEn) && !strobeActive && !$past(strobeActive)) |-> $stable(dout))
  else $error("Latched address changed while the strobe was inactive.");
endmodule

// ===== hbdl_strobe_dec.sv
// Decoder of the three read and write strobe styles.
`timescale 1ns/1ps
module hbdl_strobe_dec
  import hbdl_pkg::*;
(
  hbdl_strobe_if.dec bus
);
  always_comb begin
    unique case (bus.style)
      HBDL_SEP: begin
        bus.readAct = !bus.rdPin;
        bus.writeAct = !bus.wrPin;
      end
      HBDL_ENA: begin
        bus.readAct = bus.rdPin && bus.wrPin;
        bus.writeAct = bus.rdPin && !bus.wrPin;
      end
      HBDL_DS: begin
        bus.readAct = !bus.rdPin && bus.wrPin;
        bus.writeAct = !bus.rdPin && !bus.wrPin;
      end
      default: begin
        bus.readAct = 1'b0;
        bus.writeAct = 1'b0;
      end
    endcase
  end
endmodule

// ===== hbdl_host_model.sv
// Host controller model that drives the block's bus pins in the configured strobe style.
`timescale 1ns/1ps
module hbdl_host_model
  import hbdl_pkg::*;
(
  input wire logic sys_clk,
  output logic addrStrobe,
  output logic rdStrobePin,
  output logic wrStrobePin,
  output logic sharedPin,
  output logic [15:0] addrIn,
  output logic [3:0] highAddrIn,
  output logic [15:0] dataIn
);
  hbdl_style_t style;
  logic aleHigh;

  initial begin
    style = HBDL_SEP;
    aleHigh = 1'b1;
    {addrStrobe, rdStrobePin, wrStrobePin, sharedPin} = 4'h7;
    addrIn = 16'h0000;
    highAddrIn = 4'h0;
    dataIn = 16'h0000;
  end

  // Pins move only after a falling edge, so the block always samples settled levels.
  task automatic cycle(input logic rd, input logic wr, input logic as, input logic fe, input logic [15:0] a,
                       input logic [15:0] d);
    @(negedge sys_clk);
    addrStrobe = as ~^ aleHigh;
    sharedPin = !fe;
    case (style)
      HBDL_SEP: rdStrobePin = !rd;
      HBDL_ENA: rdStrobePin = rd | wr;
      default: rdStrobePin = !(rd | wr);
    endcase
    wrStrobePin = !wr;
    addrIn = a;
    highAddrIn = a[15:12];
    // A released data bus shows the inverse of its last value, so a stale copy can never pass.
    dataIn = (rd || (!wr && !as)) ? ~dataIn : d;
  endtask
endmodule

// ===== hbdl_host_bus_decode_latch_tb.sv
// Self-checking testbench of the host bus decode and latch block against a behavioural model.
`timescale 1ns/1ps
module hbdl_host_bus_decode_latch_tb;
  import hbdl_pkg::*;
  logic sys_clk, reset_n, ioBaseSelect, sramDecode;
  logic highAddrLatchSel, highAddrRoleSel, wideBusSel, muxedBusSel, nonmuxLatchSel;
  logic spaceSplitSel, strobeStyleSel, dataStrobeSel, aleActiveHighSel;
  logic [8:0] cfg;
  logic [7:0] bankDecode, codeBankSelects;
  logic addrStrobe, rdStrobePin, wrStrobePin, sharedPin;
  logic [15:0] addrIn, dataIn, latchedAddr, dataOut, dataOe;
  logic [3:0] highAddrIn, highAddrLogic, decoderHighAddr, pageOutputs;
  logic sramSelect, sramRead, sramWrite, sramWordMode, codeRead, programFetch, readStrobe, writeStrobe;
  logic lowerLaneEn, upperLaneEn;
  int miscompares, checksDone;

  assign {highAddrLatchSel, highAddrRoleSel, wideBusSel, muxedBusSel, nonmuxLatchSel, spaceSplitSel,
          strobeStyleSel, dataStrobeSel, aleActiveHighSel} = cfg;

  hbdl_host_model hbdl_host_model_inst (.sys_clk, .addrStrobe, .rdStrobePin, .wrStrobePin, .sharedPin,
    .addrIn, .highAddrIn, .dataIn);

  hbdl_host_bus_decode_latch hbdl_host_bus_decode_latch_inst (.sys_clk, .reset_n, .highAddrLatchSel,
    .highAddrRoleSel, .wideBusSel, .muxedBusSel, .nonmuxLatchSel, .spaceSplitSel, .strobeStyleSel,
    .dataStrobeSel, .aleActiveHighSel, .addrStrobe, .rdStrobePin, .wrStrobePin, .sharedPin, .addrIn,
    .highAddrIn, .dataIn, .ioBaseSelect, .bankDecode, .sramDecode, .latchedAddr, .highAddrLogic,
    .decoderHighAddr, .pageOutputs, .codeBankSelects, .sramSelect, .sramRead, .sramWrite, .sramWordMode,
    .codeRead, .programFetch, .readStrobe, .writeStrobe, .lowerLaneEn, .upperLaneEn, .dataOut, .dataOe);

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic finalReport();
    $display("checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] want, input string msg);
    checksDone++;
    if (got !== want) begin
      miscompares++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, want);
    end
  endtask

  task automatic cyc(input logic rd, input logic wr, input logic as, input logic fe, input logic [15:0] a,
                     input logic [15:0] d);
    hbdl_host_model_inst.cycle(rd, wr, as, fe, a, d);
  endtask

  task automatic chkSel();
    logic [1:0] rw;
    logic cr;
    if (!strobeStyleSel) rw = {!rdStrobePin, !wrStrobePin};
    else if (!dataStrobeSel) rw = {rdStrobePin & wrStrobePin, rdStrobePin & !wrStrobePin};
    else rw = {!rdStrobePin & wrStrobePin, !rdStrobePin & !wrStrobePin};
    cr = (spaceSplitSel && !wideBusSel) ? !sharedPin : rw[1];
    chk(16'({readStrobe, writeStrobe}), 16'(rw), "strobes");
    chk(16'({sramSelect, sramRead, sramWrite}), 16'({sramDecode, rw & {2{sramDecode}}}), "sram");
    chk(16'(codeBankSelects), 16'(bankDecode & {8{cr}}), "banks");
    chk(16'({codeRead, programFetch}), 16'({cr, !wideBusSel & !sharedPin}), "fetch");
  endtask

  task automatic run(input logic [8:0] c);
    logic [15:0] a;
    logic [3:0] h;
    logic r;
    @(negedge sys_clk);
    cfg = c;
    reset_n = 1'b0;
    hbdl_host_model_inst.style = hbdl_style_t'({c[1] & c[2], c[2]});
    hbdl_host_model_inst.aleHigh = c[0];
    repeat (10) @(negedge sys_clk);
    chk(16'(pageOutputs), 16'h0000, "page reset");
    chk(dataOe, 16'h0000, "oe reset");
    reset_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    cfg[6] = !c[6];
    @(negedge sys_clk);
    chk(16'(sramWordMode), 16'(c[6]), "word mode");
    cfg = c;
    a = 16'($urandom);
    cyc(1'b0, 1'b0, 1'b1, 1'b0, a, a);
    #1 chk(latchedAddr, a, "open latch");
    cyc(1'b0, 1'b0, 1'b0, 1'b0, ~a, ~a);
    h = highAddrLatchSel ? a[15:12] : ~a[15:12];
    #1 chk(latchedAddr, {((muxedBusSel ? wideBusSel : nonmuxLatchSel) ? a[15:8] : ~a[15:8]),
                         ((muxedBusSel | nonmuxLatchSel) ? a[7:0] : ~a[7:0])}, "addr hold");
    chk(16'({highAddrLogic, decoderHighAddr}), 16'({h, highAddrRoleSel ? h : 4'h0}), "high");
    repeat (12) begin
      r = 1'($urandom);
      cyc(r, !r & 1'($urandom), 1'b0, (spaceSplitSel | wideBusSel) & 1'($urandom), 16'($urandom), 16'($urandom));
      bankDecode = 8'($urandom);
      sramDecode = 1'($urandom);
      #1 chkSel();
    end
    h = 4'($urandom);
    cyc(1'b0, 1'b0, 1'b1, 1'b0, 16'h0018, 16'h0018);
    ioBaseSelect = 1'b1;
    cyc(1'b0, 1'b1, 1'b0, 1'b0, 16'h0018, {12'hfff, h});
    cyc(1'b0, 1'b0, 1'b0, 1'b0, 16'h0018, 16'h0018);
    #1 chk(16'(pageOutputs), 16'(h), "page write");
    cyc(1'b1, 1'b0, 1'b0, 1'b0, 16'h0018, 16'h0018);
    cyc(1'b0, 1'b0, 1'b0, 1'b0, 16'h0018, 16'h0018);
    #1 chk(dataOut, 16'(h), "page read");
    chk(dataOe, 16'h00ff, "page oe");
    @(negedge sys_clk);
    ioBaseSelect = 1'b0;
    if (wideBusSel) begin
      for (int i = 0; i < 4; i++) begin
        cyc(1'b0, 1'b0, 1'b1, !i[1], 16'(i[0]), 16'(i[0]));
        #1 chk(16'({upperLaneEn, lowerLaneEn}), 16'({!i[1], !i[0]}), "lanes");
      end
      cyc(1'b0, 1'b0, 1'b0, 1'b1, 16'h0003, 16'h0003);
      #1 chk(16'(upperLaneEn), 16'(!muxedBusSel), "upper hold");
    end
  endtask

  initial begin
    void'($urandom(79630));
    miscompares = 0;
    checksDone = 0;
    reset_n = 1'b0;
    cfg = 9'h000;
    ioBaseSelect = 1'b0;
    sramDecode = 1'b0;
    bankDecode = 8'h00;
    run(9'h089);
    run(9'h164);
    run(9'h1a7);
    run(9'h051);
    finalReport();
  end

  // A hang would otherwise run forever, since the clock generator above never stops.
  initial begin
    #100000;
    miscompares++;
    finalReport();
  end
endmodule
